// >>> rtl/setpoint_pkg.sv
package setpoint_pkg;

  // bus address: 0x30 on writes, 0x31 on reads
  localparam logic [6:0] DEV_ADDR = 7'h18;
  localparam logic [7:0] ADDR_WR = 8'h30;
  localparam logic [7:0] ADDR_RD = 8'h31;

  // register command codes
  localparam logic [7:0] CMD_CV = 8'h10;
  localparam logic [7:0] CMD_STATUS = 8'h14;
  localparam logic [7:0] CMD_VDAC = 8'h5c;
  localparam logic [7:0] CMD_PTR = 8'h80;
  localparam logic [7:0] CMD_CC = 8'h98;

  // voltage setpoint, 10 mV per lsb: 3 V .. 24 V, 5 V after reset
  localparam logic [13:0] CV_MIN = 14'h012c;
  localparam logic [13:0] CV_MAX = 14'h0960;
  localparam logic [13:0] CV_RST = 14'h01f4;

  // current setpoint, 1/128 of full scale per step: 20 % .. 100 %
  localparam logic [13:0] CC_MIN = 14'h0019;
  localparam logic [13:0] CC_MAX = 14'h0080;
  localparam logic [7:0] CC_RST = 8'h80;

  // ready flag position in the status word
  localparam int READY_BIT = 14;

  // link timing: 100 kHz bit rate from the 40 MHz clock
  localparam int CLK_NS = 25;
  localparam int BIT_NS = 10000;
  localparam int QTR_CYC = BIT_NS / (4 * CLK_NS);

  // host operations
  localparam logic OP_WRITE = 1'b0;
  localparam logic OP_READ = 1'b1;

  // device receiver states
  typedef enum logic [2:0] {
    st_idle, st_addr, st_ack, st_wr, st_rd, st_rack, st_rnxt
  } dev_st_e;

  // host sequencer slot kinds
  typedef enum logic [2:0] {
    k_start, k_wr, k_rdack, k_rdnack, k_stop, k_end
  } step_kind_e;

  typedef struct packed {
    step_kind_e kind;
    logic [7:0] data;
  } step_s;

  // 14-bit value to word: odd parity at bit 7 and bit 15
  function automatic logic [15:0] par_enc(input logic [13:0] v);
    par_enc = {~^v[13:7], v[13:7], ~^v[6:0], v[6:0]};
  endfunction

  // both halves of a received word must hold odd parity
  function automatic logic par_ok(input logic [15:0] w);
    par_ok = (^w[7:0]) & (^w[15:8]);
  endfunction

  // strip the parity bits back out
  function automatic logic [13:0] par_dec(input logic [15:0] w);
    par_dec = {w[14:8], w[6:0]};
  endfunction

endpackage

// >>> rtl/power_i2c_if.sv
`timescale 1ns/100ps
`default_nettype none
// two-wire link; open-drain lines resolved here from the enables
interface power_i2c_if;
  logic host_scl_oe; // host pulls clock low
  logic host_sda_oe; // host pulls data low
  logic dev_sda_oe; // device pulls data low
  logic scl; // resolved clock level
  logic sda; // resolved data level

  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport device (input scl, input sda, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_oe, output host_sda_oe);
endinterface
`default_nettype wire

// >>> rtl/setpoint_dev.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - host polls ready before transactions, after resets; host refuses only writes until a status read sees ready
// - ready flag set only when commands accepted
// - host loads status code into read pointer
// - pointer read returns word, ready at bit 14
// - pointer code sent twice, then read transfer
// - address 0x30 writes, 0x31 reads
// - write order: address, command, low, high
// - setpoint words carry odd parity bits
// - voltage setpoint 3-24 V in 10 mV
// - voltage setpoint resets to 5 V
// - current setpoint command code is 0x98
// - current setpoint codes 25 to 128 accepted
// - each current step is 1/128 full scale
// - current regulation compares setpoint with average
module setpoint_dev (
  input wire logic i_clk,
  input wire logic i_srst,
  power_i2c_if.device bus,
  input wire logic i_ready,
  input wire logic [13:0] i_status_flags,
  input wire logic [7:0] i_avg_current,
  output logic [13:0] o_cv_setpoint,
  output logic [7:0] o_cc_setpoint,
  output logic o_cc_limit
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    setpoint_pkg::dev_st_e st; // receiver state
    logic scl_q; // clock one cycle ago
    logic sda_q; // data one cycle ago
    logic [3:0] cnt; // bit counter in the byte
    logic [7:0] sh; // incoming shift register
    logic rw; // direction bit of the address
    logic [1:0] idx; // data bytes taken since the address
    logic [7:0] cmd; // register command code
    logic [7:0] low_byte; // low data byte
    logic [7:0] hi; // high data byte
    logic [7:0] ptr; // read-back pointer
    logic [7:0] tx; // outgoing byte
    logic hib; // high byte is next
    logic sda_oe; // we pull data low
    logic [13:0] cv; // voltage setpoint
    logic [7:0] cc; // current setpoint
    logic lim; // current at or above setpoint
  } dev_s;

  dev_s q; // registered state
  dev_s n; // next state

  ////////////////////////////////////////////////////////////////////////
  // read-back word selected by the pointer

  function automatic logic [15:0] sel_word(input logic [7:0] p, input dev_s s);
    sel_word = 16'h0000;
    unique case (p)
      setpoint_pkg::CMD_STATUS:
        sel_word = {1'b0, i_ready, i_status_flags};
      setpoint_pkg::CMD_CV:
        sel_word = setpoint_pkg::par_enc(s.cv);
      setpoint_pkg::CMD_VDAC:
        sel_word = setpoint_pkg::par_enc(s.cv);
      setpoint_pkg::CMD_CC:
        sel_word = setpoint_pkg::par_enc({6'h00, s.cc});
      default:
        sel_word = 16'h0000; // unknown codes read as zero
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  // lines are sampled directly; they are synchronous to i_clk

  always_comb
  begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [15:0] word;
    logic [15:0] wr_word;
    logic [13:0] val;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    word = sel_word(q.ptr, q);
    wr_word = {q.hi, q.low_byte};
    val = setpoint_pkg::par_dec(wr_word);
    n = q;
    n.scl_q = bus.scl;
    n.sda_q = bus.sda;
    rise = bus.scl & ~q.scl_q;
    fall = ~bus.scl & q.scl_q;
    start = q.scl_q & bus.scl & q.sda_q & ~bus.sda;
    stop = q.scl_q & bus.scl & ~q.sda_q & bus.sda;
    // averaged current against the setpoint, same 1/128 scale
    n.lim = (i_avg_current >= q.cc);
    if (start)
    begin
      // a start always restarts the receiver, even mid-byte
      n.st = setpoint_pkg::st_addr;
      n.cnt = 4'h0;
      n.idx = 2'h0;
      n.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      // writes land only at the stop, so a cut-off setpoint frame changes nothing; a pointer frame needs only one code byte
      n.st = setpoint_pkg::st_idle;
      n.sda_oe = 1'b0;
      if (q.cmd == setpoint_pkg::CMD_CV && q.idx == 2'h3 && setpoint_pkg::par_ok(wr_word)
          && val >= setpoint_pkg::CV_MIN && val <= setpoint_pkg::CV_MAX)
      begin
        n.cv = val;
      end
      if (q.cmd == setpoint_pkg::CMD_CC && q.idx == 2'h3 && setpoint_pkg::par_ok(wr_word)
          && val >= setpoint_pkg::CC_MIN && val <= setpoint_pkg::CC_MAX)
      begin
        n.cc = val[7:0];
      end
      if (q.cmd == setpoint_pkg::CMD_PTR && q.idx >= 2'h2)
      begin
        n.ptr = q.low_byte; // the repeated code byte is only a copy
      end
    end
    else
    begin
      unique case (q.st)
        setpoint_pkg::st_idle:
        begin
          // wait for a start
        end
        setpoint_pkg::st_addr, setpoint_pkg::st_wr:
        begin
          if (rise)
          begin
            n.sh = {q.sh[6:0], bus.sda};
            n.cnt = q.cnt + 4'h1;
          end
          else if (fall && q.cnt == 4'h8)
          begin
            n.cnt = 4'h0;
            if (q.st == setpoint_pkg::st_addr)
            begin
              // not ready: stay silent so the host sees a nack
              if (q.sh[7:1] == setpoint_pkg::DEV_ADDR && i_ready)
              begin
                n.rw = q.sh[0];
                n.sda_oe = 1'b1;
                n.st = setpoint_pkg::st_ack;
              end
              else
              begin
                n.st = setpoint_pkg::st_idle;
              end
            end
            else
            begin
              // command first, then low byte, then high byte
              unique case (q.idx)
                2'h0: n.cmd = q.sh;
                2'h1: n.low_byte = q.sh;
                2'h2: n.hi = q.sh;
                2'h3: n.hi = q.hi; // extra bytes are acked and dropped
              endcase
              if (q.idx != 2'h3)
              begin
                n.idx = q.idx + 2'h1;
              end
              n.sda_oe = 1'b1;
              n.st = setpoint_pkg::st_ack;
            end
          end
        end
        setpoint_pkg::st_ack:
        begin
          if (fall)
          begin
            n.sda_oe = 1'b0;
            if (q.rw)
            begin
              // read: low byte of the pointed word goes first
              n.tx = word[7:0];
              n.hib = 1'b1;
              n.sda_oe = ~word[7];
              n.cnt = 4'h0;
              n.st = setpoint_pkg::st_rd;
            end
            else
            begin
              n.st = setpoint_pkg::st_wr;
            end
          end
        end
        setpoint_pkg::st_rd:
        begin
          if (fall)
          begin
            if (q.cnt == 4'h7)
            begin
              n.sda_oe = 1'b0;
              n.st = setpoint_pkg::st_rack;
            end
            else
            begin
              n.tx = {q.tx[6:0], 1'b0};
              n.sda_oe = ~q.tx[6];
              n.cnt = q.cnt + 4'h1;
            end
          end
        end
        setpoint_pkg::st_rack:
        begin
          // a nack from the host ends the read
          if (rise)
          begin
            n.st = bus.sda ? setpoint_pkg::st_idle : setpoint_pkg::st_rnxt;
          end
        end
        setpoint_pkg::st_rnxt:
        begin
          if (fall)
          begin
            // bytes alternate low, high, low, ... if the host reads on
            n.tx = q.hib ? word[15:8] : word[7:0];
            n.sda_oe = q.hib ? ~word[15] : ~word[7];
            n.hib = ~q.hib;
            n.cnt = 4'h0;
            n.st = setpoint_pkg::st_rd;
          end
        end
        default:
        begin
          n.st = setpoint_pkg::st_idle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      q <= '0;
      q.scl_q <= 1'b1;
      q.sda_q <= 1'b1;
      q.cv <= setpoint_pkg::CV_RST;
      q.cc <= setpoint_pkg::CC_RST;
    end
    else
    begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign bus.dev_sda_oe = q.sda_oe;
  assign o_cv_setpoint = q.cv;
  assign o_cc_setpoint = q.cc;
  assign o_cc_limit = q.lim;

endmodule
`default_nettype wire

// >>> rtl/setpoint_host.sv
`timescale 1ns/100ps
`default_nettype none
// bus master that programs setpoints and reads status back
module setpoint_host (
  input wire logic i_clk,
  input wire logic i_srst,
  power_i2c_if.host bus,
  input wire logic i_req,
  input wire logic i_op,
  input wire logic [7:0] i_code,
  input wire logic [13:0] i_value,
  input wire logic i_device_reset,
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic o_refused,
  output logic [15:0] o_rdata,
  output logic o_ready_seen
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic busy; // transfer in progress
    logic op; // write or read
    logic [7:0] code; // command or pointer code
    logic [15:0] word; // parity-coded write word
    logic [3:0] step; // slot in the program
    logic [3:0] bitn; // bit within the byte slot, 8 is ack
    logic [1:0] ph; // quarter within the bit
    logic [15:0] tick; // cycles within the quarter
    logic [7:0] sh; // incoming shift register
    logic [15:0] rdata; // word read back
    logic scl_oe; // we pull clock low
    logic sda_oe; // we pull data low
    logic nack; // some byte was not acked
    logic done; // one-cycle completion pulse
    logic refused; // one-cycle refusal pulse
    logic ready_seen; // ready flag seen since device reset
  } host_s;

  host_s q; // registered state
  host_s n; // next state

  ////////////////////////////////////////////////////////////////////////
  // transfer programs, one slot per step

  function automatic setpoint_pkg::step_s prog(input logic op, input logic [3:0] s, input logic [7:0] code,
                                              input logic [15:0] w);
    prog = '{kind: setpoint_pkg::k_end, data: 8'h00};
    if (op == setpoint_pkg::OP_WRITE)
    begin
      unique case (s)
        4'h0: prog.kind = setpoint_pkg::k_start;
        4'h1: prog = '{kind: setpoint_pkg::k_wr, data: setpoint_pkg::ADDR_WR};
        4'h2: prog = '{kind: setpoint_pkg::k_wr, data: code};
        4'h3: prog = '{kind: setpoint_pkg::k_wr, data: w[7:0]};
        4'h4: prog = '{kind: setpoint_pkg::k_wr, data: w[15:8]};
        4'h5: prog.kind = setpoint_pkg::k_stop;
        default: prog.kind = setpoint_pkg::k_end;
      endcase
    end
    else
    begin
      unique case (s)
        4'h0: prog.kind = setpoint_pkg::k_start;
        4'h1: prog = '{kind: setpoint_pkg::k_wr, data: setpoint_pkg::ADDR_WR};
        4'h2: prog = '{kind: setpoint_pkg::k_wr, data: setpoint_pkg::CMD_PTR};
        4'h3: prog = '{kind: setpoint_pkg::k_wr, data: code};
        4'h4: prog = '{kind: setpoint_pkg::k_wr, data: code};
        4'h5: prog.kind = setpoint_pkg::k_stop;
        4'h6: prog.kind = setpoint_pkg::k_start;
        4'h7: prog = '{kind: setpoint_pkg::k_wr, data: setpoint_pkg::ADDR_RD};
        4'h8: prog.kind = setpoint_pkg::k_rdack;
        4'h9: prog.kind = setpoint_pkg::k_rdnack;
        4'ha: prog.kind = setpoint_pkg::k_stop;
        default: prog.kind = setpoint_pkg::k_end;
      endcase
    end
  endfunction

  // pin drive for a slot quarter, {scl_oe, sda_oe}
  function automatic logic [1:0] drv(input setpoint_pkg::step_s st, input logic [3:0] b, input logic [1:0] ph);
    logic clk_low;
    clk_low = (ph == 2'h0) || (ph == 2'h3);
    drv = 2'b00;
    unique case (st.kind)
      setpoint_pkg::k_start: drv = {ph == 2'h3, ph[1]};
      setpoint_pkg::k_stop: drv = {ph == 2'h0, ~ph[1]};
      setpoint_pkg::k_wr: drv = {clk_low, (b != 4'h8) && !st.data[3'(4'h7 - b)]};
      setpoint_pkg::k_rdack: drv = {clk_low, b == 4'h8};
      setpoint_pkg::k_rdnack: drv = {clk_low, 1'b0};
      setpoint_pkg::k_end: drv = 2'b00;
      default: drv = 2'b00; // unused kind codes leave both lines released
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    setpoint_pkg::step_s cur;
    setpoint_pkg::step_s nxt;
    logic byte_slot;
    cur = prog(q.op, q.step, q.code, q.word);
    nxt = cur;
    byte_slot = (cur.kind == setpoint_pkg::k_wr) || (cur.kind == setpoint_pkg::k_rdack)
                || (cur.kind == setpoint_pkg::k_rdnack);
    n = q;
    n.done = 1'b0;
    n.refused = 1'b0;
    // a device reset means its ready flag must be seen again
    if (i_device_reset)
    begin
      n.ready_seen = 1'b0;
    end
    if (!q.busy)
    begin
      if (i_req)
      begin
        if (i_op == setpoint_pkg::OP_WRITE && !q.ready_seen)
        begin
          n.refused = 1'b1;
        end
        else
        begin
          n.busy = 1'b1;
          n.op = i_op;
          n.code = i_code;
          n.word = setpoint_pkg::par_enc(i_value);
          n.step = 4'h0;
          n.bitn = 4'h0;
          n.ph = 2'h0;
          n.tick = 16'h0000;
          n.nack = 1'b0;
        end
      end
    end
    else if (q.tick == 16'(setpoint_pkg::QTR_CYC - 1))
    begin
      n.tick = 16'h0000;
      n.ph = q.ph + 2'h1;
      // sample in the middle of the high clock phase
      if (q.ph == 2'h1 && byte_slot && q.bitn != 4'h8)
      begin
        n.sh = {q.sh[6:0], bus.sda};
      end
      if (q.ph == 2'h1 && cur.kind == setpoint_pkg::k_wr && q.bitn == 4'h8)
      begin
        n.nack = q.nack | bus.sda;
      end
      if (q.ph == 2'h3)
      begin
        if (byte_slot && q.bitn != 4'h8)
        begin
          n.bitn = q.bitn + 4'h1;
        end
        else
        begin
          n.bitn = 4'h0;
          n.step = q.step + 4'h1;
          if (cur.kind == setpoint_pkg::k_rdack)
          begin
            n.rdata[7:0] = q.sh;
          end
          if (cur.kind == setpoint_pkg::k_rdnack)
          begin
            n.rdata[15:8] = q.sh;
          end
        end
      end
      nxt = prog(q.op, n.step, q.code, q.word);
      if (nxt.kind == setpoint_pkg::k_end)
      begin
        n.busy = 1'b0;
        n.done = 1'b1;
        if (q.op == setpoint_pkg::OP_READ && q.code == setpoint_pkg::CMD_STATUS)
        begin
          n.ready_seen = !n.nack && n.rdata[setpoint_pkg::READY_BIT];
        end
      end
      {n.scl_oe, n.sda_oe} = drv(nxt, n.bitn, n.ph);
    end
    else
    begin
      n.tick = q.tick + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign bus.host_scl_oe = q.scl_oe;
  assign bus.host_sda_oe = q.sda_oe;
  assign o_busy = q.busy;
  assign o_done = q.done;
  assign o_nack = q.nack;
  assign o_refused = q.refused;
  assign o_rdata = q.rdata;
  assign o_ready_seen = q.ready_seen;

endmodule
`default_nettype wire

// >>> test/setpoint_link_checker.sv
`timescale 1ns/100ps
`default_nettype none
// watches the two-wire link between host and device ends
module setpoint_link_checker (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking dck @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////
  // reset must leave every line released, so no attempt is disabled
  property p_rst_idle;
    disable iff (1'b0) i_srst |=> !host_scl_oe && !host_sda_oe && !dev_sda_oe;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("line held in reset");
  // device ack starts only while the clock is low
  property p_ack_rise;
    $rose(dev_sda_oe) |-> !scl;
  endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("ack rose with clock high");
  property p_ack_fall;
    $fell(dev_sda_oe) |-> !scl;
  endproperty
  a_ack_fall: assert property (p_ack_fall) else $error("ack fell with clock high");
  // device data must not move while the clock is high
  property p_dev_stable;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  a_dev_stable: assert property (p_dev_stable) else $error("device data moved");
  property p_ack_hold;
    $rose(dev_sda_oe) |=> dev_sda_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
  // a start is followed by clocking within one bit time
  property p_start_clk;
    scl && $past(scl) && $fell(sda) |-> ##[1:400] !scl;
  endproperty
  a_start_clk: assert property (p_start_clk) else $error("no clock after start");
  // after a stop the device leaves the bus alone
  property p_stop_idle;
    scl && $past(scl) && $rose(sda) |=> (scl && !dev_sda_oe) [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("bus busy after stop");
  property p_scl_low;
    $fell(scl) |-> ##[1:400] scl;
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("clock low too long");
  // both ends pulling data low is only tolerated while clock is low
  property p_no_clash;
    dev_sda_oe && host_sda_oe |-> !scl;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("data clash");
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// drives host user side and device inputs, checks results
module tb_top;
  typedef struct {
    logic refused;
    logic rd;
    logic [15:0] rdata;
    logic [13:0] cv;
    logic [7:0] cc;
    logic seen;
  } exp_s;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic req = 1'b0;
  logic op = 1'b0;
  logic [7:0] code = 8'h00;
  logic [13:0] value = 14'h0000;
  logic dev_rst = 1'b0;
  logic ready = 1'b0;
  logic [13:0] flags = 14'h0000;
  logic [7:0] avg = 8'h00;
  logic busy, done, nack, refused, seen, cc_limit;
  logic [15:0] rdata;
  logic [13:0] cv;
  logic [7:0] cc;
  exp_s exp_q[$]; // expected results, oldest first
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  integer seed = 32'hc6d1_2e8a;
  ////////////////////////////////////////////////////////////
  always #12.5 i_clk = ~i_clk;
  power_i2c_if power_i2c_if_inst ();
  setpoint_host setpoint_host_inst (.i_clk(i_clk), .i_srst(i_srst), .bus(power_i2c_if_inst.host),
    .i_req(req), .i_op(op), .i_code(code), .i_value(value), .i_device_reset(dev_rst), .o_busy(busy),
    .o_done(done), .o_nack(nack), .o_refused(refused), .o_rdata(rdata), .o_ready_seen(seen));
  setpoint_dev setpoint_dev_inst (.i_clk(i_clk), .i_srst(i_srst), .bus(power_i2c_if_inst.device),
    .i_ready(ready), .i_status_flags(flags), .i_avg_current(avg), .o_cv_setpoint(cv),
    .o_cc_setpoint(cc), .o_cc_limit(cc_limit));
  setpoint_link_checker setpoint_link_checker_inst (.i_clk(i_clk), .i_srst(i_srst),
    .host_scl_oe(power_i2c_if_inst.host_scl_oe), .host_sda_oe(power_i2c_if_inst.host_sda_oe),
    .dev_sda_oe(power_i2c_if_inst.dev_sda_oe), .scl(power_i2c_if_inst.scl), .sda(power_i2c_if_inst.sda));
  ////////////////////////////////////////////////////////////
  task automatic compare_word(input string what, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic compare_bit(input string what, input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic exp_s mk(logic f, logic r, logic [15:0] d, logic [13:0] v, logic [7:0] c, logic s);
    mk = '{refused: f, rd: r, rdata: d, cv: v, cc: c, seen: s};
  endfunction
  // one-cycle request, then wait until the monitor took the note
  task automatic issue(input logic o, input logic [7:0] c, input logic [13:0] v, input exp_s e);
    exp_q.push_back(e);
    req <= 1'b1;
    op <= o;
    code <= c;
    value <= v;
    @(posedge i_clk);
    req <= 1'b0;
    while (exp_q.size() != 0)
      @(posedge i_clk);
    repeat (4) @(posedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////
  // monitor: each done or refused pulse consumes the oldest note
  initial
  begin : monitor
    exp_s e;
    logic f;
    forever
    begin
      @(posedge i_clk);
      if (done === 1'b1 || refused === 1'b1)
      begin
        f = refused;
        if (exp_q.size() == 0)
          e = mk(1'bx, 1'b0, 16'h0000, 14'h0000, 8'h00, 1'bx);
        else
          e = exp_q.pop_front();
        // writes commit after the stop, so give them time to land
        repeat (2) @(posedge i_clk);
        compare_bit("refused", e.refused, f);
        compare_word("cv", {2'b00, e.cv}, {2'b00, cv});
        compare_word("cc", {8'h00, e.cc}, {8'h00, cc});
        compare_bit("ready_seen", e.seen, seen);
        compare_bit("busy", 1'b0, busy);
        if (e.rd)
          compare_word("rdata", e.rdata, rdata);
        if (!e.refused)
          compare_bit("nack", 1'b0, nack);
      end
    end
  end
  // hang guard: the run needs about 72500 cycles
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin : main
    logic [13:0] fl;
    logic [13:0] cv_e;
    logic [7:0] cc_e;
    logic [7:0] av;
    cv_e = setpoint_pkg::CV_RST;
    cc_e = setpoint_pkg::CC_RST;
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    // a write before any ready poll is turned away
    issue(setpoint_pkg::OP_WRITE, setpoint_pkg::CMD_CV, 14'h0320, mk(1'b1, 1'b0, 16'h0000, cv_e, cc_e, 1'b0));
    fl = 14'($random(seed));
    ready <= 1'b1;
    flags <= fl;
    @(posedge i_clk);
    issue(setpoint_pkg::OP_READ, setpoint_pkg::CMD_STATUS, 14'h0000,
      mk(1'b0, 1'b1, {1'b0, 1'b1, fl}, cv_e, cc_e, 1'b1));
    cv_e = 14'(300 + ($unsigned($random(seed)) % 2101));
    issue(setpoint_pkg::OP_WRITE, setpoint_pkg::CMD_CV, cv_e, mk(1'b0, 1'b0, 16'h0000, cv_e, cc_e, 1'b1));
    // just below the lowest current code: must be dropped
    issue(setpoint_pkg::OP_WRITE, setpoint_pkg::CMD_CC, 14'h0018, mk(1'b0, 1'b0, 16'h0000, cv_e, cc_e, 1'b1));
    cc_e = 8'h19;
    issue(setpoint_pkg::OP_WRITE, setpoint_pkg::CMD_CC, 14'h0019, mk(1'b0, 1'b0, 16'h0000, cv_e, cc_e, 1'b1));
    // limit flag follows average current against the new code
    repeat (8)
    begin
      av = 8'($random(seed)) & 8'h3f;
      avg <= av;
      repeat (3) @(posedge i_clk);
      compare_bit("cc_limit", av >= cc_e, cc_limit);
    end
    dev_rst <= 1'b1;
    @(posedge i_clk);
    dev_rst <= 1'b0;
    @(posedge i_clk);
    // device reset forgets the poll, so writes are refused again
    issue(setpoint_pkg::OP_WRITE, setpoint_pkg::CMD_CV, 14'h0400, mk(1'b1, 1'b0, 16'h0000, cv_e, cc_e, 1'b0));
    report_and_stop();
  end
endmodule
`default_nettype wire
